/* File: core/lrg_regs.sv */
// register slice: colour table port, general pins, scratch, rotation mode, stride, frame timing
//
// Contract
// (RQ1) data port bits 7-4 access colour table entry at current pointer
// (RQ2) every data port read or write advances the pointer by one
// (RQ3) red and green staged; all three committed when blue written
// (RQ4) direction bit 0: pin is input, level bit reads sampled pin
// (RQ5) direction bit 1: pin driven from written level bit
// (RQ6) pins with dedicated panel function ignore their direction bit
// (RQ7) eight-bit scratch register stores and returns value, no side effect
// (RQ8) rotation enable selects rotated display; clear ignores variant bit
// (RQ9) variant bit picks default rotated mode at 0, alternate at 1
// (RQ10) software writes 0 to rotation register reserved bit
// (RQ11) landscape: select ignored, pixel clock is base, memory by config bit
// (RQ12) default rotated: both clocks base divided by 1,2,4,8
// (RQ13) alternate rotated: pixel /2,/2,/4,/8, memory /1,/1,/2,/4
// (RQ14) base clock is input clock, or half of it when prescale set
// (RQ15) stride n bytes for 1..FFh, zero means 256 bytes
// (RQ16) software never writes the two factory test locations
// (RQ17) horizontal display period is (size field plus one) times 8
// (RQ18) horizontal blank period is (blank field plus four) times 8
// (RQ19) vertical display period is ten-bit size plus one lines
// (RQ20) vertical blank period equals six-bit field, no offset
// (RQ21) three 256-entry four-bit tables, red, green and blue
// (RQ22) writing table address loads index and resets selector to red
// (RQ23) accesses step red, green, blue, then red of next index
// (RQ24) level bit of an output pin reads back last written value
// (RQ25) reset clears all registers: landscape, all pins inputs
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "lrg_consts.svh"

module lrg_regs #(
  parameter int NPINS = 5,
  parameter int TBL_DEPTH = 256,
  parameter int TBL_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // general pins
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_dedicated,
  // clock configuration from the rest of the controller
  input wire logic base_prescale,
  input wire logic mem_clk_cfg,
  // timing fields from the timing registers
  input wire logic [6:0] hsize_field,
  input wire logic [4:0] hblank_field,
  input wire logic [9:0] vsize_field,
  input wire logic [5:0] vblank_field,
  // decoded results
  output lrg_pkg::lrg_mode_t disp_mode,
  output lrg_pkg::lrg_clk_sel_t clk_sel,
  output logic [8:0] line_stride,
  output lrg_pkg::lrg_timing_t timing
);

  typedef struct packed {
    logic [7:0] idx;
    lrg_pkg::lrg_colour_t col;
    logic [TBL_W-1:0] stage_r;
    logic [TBL_W-1:0] stage_g;
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] lvl;
    logic [NPINS-1:0] pin_sync;
    logic [7:0] scratch;
    logic [7:0] rot;
    logic [7:0] stride;
    logic [7:0] rdata;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    lrg_pkg::lrg_mode_t mode;
    lrg_pkg::lrg_clk_sel_t csel;
    logic [8:0] stride_eff;
    lrg_pkg::lrg_timing_t tim;
  } lrg_state_t;

  lrg_state_t st_r;
  lrg_state_t st_nxt;
  lrg_pkg::lrg_bus_req_t req;

  // colour tables held apart from the state struct since they are memories
  logic [TBL_W-1:0] tbl_red [TBL_DEPTH];
  logic [TBL_W-1:0] tbl_grn [TBL_DEPTH];
  logic [TBL_W-1:0] tbl_blu [TBL_DEPTH];
  logic tbl_commit;
  logic port_hit;
  logic [TBL_W-1:0] tbl_rd_val;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign port_hit = (req.addr == `LRG_OFF_TBL_DATA) && (req.wr || req.rd);
  // commit only on the blue write; red and green sit in staging meanwhile
  assign tbl_commit = req.wr && (req.addr == `LRG_OFF_TBL_DATA)
                      && (st_r.col == lrg_pkg::LRG_BLUE); // RQ3

  always_comb begin
    case (st_r.col) // RQ1
      lrg_pkg::LRG_RED: tbl_rd_val = tbl_red[st_r.idx];
      lrg_pkg::LRG_GREEN: tbl_rd_val = tbl_grn[st_r.idx];
      lrg_pkg::LRG_BLUE: tbl_rd_val = tbl_blu[st_r.idx];
      default: tbl_rd_val = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = `LRG_RST_BYTE;
    st_nxt.pin_sync = pin_in;
    if (req.wr) begin
      case (req.addr)
        `LRG_OFF_TBL_ADDR: begin
          st_nxt.idx = req.wdata; // RQ22
          st_nxt.col = lrg_pkg::LRG_RED; // RQ22
        end
        `LRG_OFF_TBL_DATA: begin
          if (st_r.col == lrg_pkg::LRG_RED) begin
            st_nxt.stage_r = req.wdata[`LRG_TBL_DATA_LSB +: TBL_W]; // RQ3
          end else if (st_r.col == lrg_pkg::LRG_GREEN) begin
            st_nxt.stage_g = req.wdata[`LRG_TBL_DATA_LSB +: TBL_W]; // RQ3
          end
        end
        `LRG_OFF_PIN_DIR: st_nxt.dir = req.wdata[NPINS-1:0];
        `LRG_OFF_PIN_LVL: st_nxt.lvl = req.wdata[NPINS-1:0];
        `LRG_OFF_SCRATCH: st_nxt.scratch = req.wdata; // RQ7
        // reserved bit and unused bits held at zero; software keeps bit 2 clear
        `LRG_OFF_ROT_MODE: st_nxt.rot = req.wdata & `LRG_ROT_WR_MASK; // RQ10
        `LRG_OFF_STRIDE: st_nxt.stride = req.wdata;
        // factory test locations absorb writes with no effect
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `LRG_OFF_TBL_ADDR: st_nxt.rdata = st_r.idx;
        `LRG_OFF_TBL_DATA: st_nxt.rdata = {tbl_rd_val, 4'h0}; // RQ1
        `LRG_OFF_PIN_DIR: st_nxt.rdata = 8'({st_r.dir});
        `LRG_OFF_PIN_LVL: st_nxt.rdata = 8'((st_r.dir & st_r.lvl)
                                         | (~st_r.dir & st_r.pin_sync)); // RQ4 RQ24
        `LRG_OFF_SCRATCH: st_nxt.rdata = st_r.scratch; // RQ7
        `LRG_OFF_ROT_MODE: st_nxt.rdata = st_r.rot;
        `LRG_OFF_STRIDE: st_nxt.rdata = st_r.stride;
        default: st_nxt.rdata = `LRG_RST_BYTE;
      endcase
    end
    // pointer steps after each data access; the step is assigned after the address load, so the step would win
    if (port_hit) begin
      if (st_r.col == lrg_pkg::LRG_BLUE) begin
        st_nxt.col = lrg_pkg::LRG_RED; // RQ23
        st_nxt.idx = st_r.idx + 8'h01; // RQ2 RQ23
      end else begin
        st_nxt.col = lrg_pkg::lrg_colour_t'(st_r.col + 2'b01); // RQ2 RQ23
      end
    end
    // pin drive: dedicated pins leave the general path regardless of direction
    st_nxt.pin_oe = st_nxt.dir & ~pin_dedicated; // RQ5 RQ6
    st_nxt.pin_out = st_nxt.lvl & st_nxt.pin_oe; // RQ5
    // mode decode
    if (!st_nxt.rot[`LRG_ROT_EN_BIT]) begin
      st_nxt.mode = lrg_pkg::LRG_LANDSCAPE; // RQ8
    end else if (st_nxt.rot[`LRG_ROT_VAR_BIT]) begin
      st_nxt.mode = lrg_pkg::LRG_ROT_ALTERNATE; // RQ9
    end else begin
      st_nxt.mode = lrg_pkg::LRG_ROT_DEFAULT; // RQ9
    end
    // clock dividers expressed as log2 of the division from the input clock
    case (st_nxt.mode)
      lrg_pkg::LRG_ROT_DEFAULT: begin
        st_nxt.csel.pix_log2 = {2'b00, st_nxt.rot[1:0]}; // RQ12
        st_nxt.csel.mem_log2 = {2'b00, st_nxt.rot[1:0]}; // RQ12
        st_nxt.csel.mem_use_cfg = 1'b0;
      end
      lrg_pkg::LRG_ROT_ALTERNATE: begin
        if (st_nxt.rot[1] == 1'b0) begin
          st_nxt.csel.pix_log2 = 4'h1; // RQ13
          st_nxt.csel.mem_log2 = 4'h0; // RQ13
        end else begin
          st_nxt.csel.pix_log2 = {2'b00, st_nxt.rot[1:0]}; // RQ13
          st_nxt.csel.mem_log2 = {2'b00, st_nxt.rot[1:0]} - 4'h1; // RQ13
        end
        st_nxt.csel.mem_use_cfg = 1'b0;
      end
      default: begin
        st_nxt.csel.pix_log2 = 4'h0; // RQ11
        st_nxt.csel.mem_log2 = {3'b000, mem_clk_cfg}; // RQ11
        st_nxt.csel.mem_use_cfg = 1'b1; // RQ11
      end
    endcase
    // prescale halves the base clock for every selection
    if (base_prescale) begin
      st_nxt.csel.pix_log2 = st_nxt.csel.pix_log2 + 4'h1; // RQ14
      st_nxt.csel.mem_log2 = st_nxt.csel.mem_log2 + 4'h1; // RQ14
    end
    st_nxt.stride_eff = (st_nxt.stride == 8'h00) ? `LRG_STRIDE_ZERO
                        : {1'b0, st_nxt.stride}; // RQ15
    st_nxt.tim.horizontal_display_period = 11'((hsize_field + 8'h01) * `LRG_HDP_MULT); // RQ17
    st_nxt.tim.hbp = 9'((hblank_field + 6'(`LRG_HBP_ADD)) * `LRG_HDP_MULT); // RQ18
    st_nxt.tim.vertical_display_period = 11'(vsize_field) + 11'h001; // RQ19
    st_nxt.tim.vbp = vblank_field; // RQ20
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0; // RQ25
    end else begin
      st_r <= st_nxt;
    end
  end

  // tables are not reset; software loads them before use
  always_ff @(posedge clk) begin
    if (tbl_commit) begin
      tbl_red[st_r.idx] <= st_r.stage_r; // RQ3 RQ21
      tbl_grn[st_r.idx] <= st_r.stage_g; // RQ3 RQ21
      tbl_blu[st_r.idx] <= req.wdata[`LRG_TBL_DATA_LSB +: TBL_W]; // RQ3 RQ21
    end
  end

  assign rdata = st_r.rdata;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign disp_mode = st_r.mode;
  assign clk_sel = st_r.csel;
  assign line_stride = st_r.stride_eff;
  assign timing = st_r.tim;

  // data port staging, commit and read checks are built from these sequences
  sequence s_data_wr;
    wr && addr == `LRG_OFF_TBL_DATA;
  endsequence

  sequence s_data_rd;
    rd && addr == `LRG_OFF_TBL_DATA;
  endsequence

  sequence s_blue_wr;
    s_data_wr ##0 (st_r.col == lrg_pkg::LRG_BLUE);
  endsequence

  // pointer and colour selector
  a_ptr_step: assert property (@(posedge clk) disable iff (!nrst) // RQ23
    (port_hit && !(wr && addr == `LRG_OFF_TBL_ADDR) && st_r.col == lrg_pkg::LRG_BLUE)
    |=> (st_r.col == lrg_pkg::LRG_RED && st_r.idx == $past(st_r.idx) + 8'h01))
    else $error("pointer did not move to next index");

  a_col_step: assert property (@(posedge clk) disable iff (!nrst) // RQ2 RQ23
    (port_hit && st_r.col != lrg_pkg::LRG_BLUE)
    |=> (st_r.col == 2'($past(st_r.col) + 2'b01) && st_r.idx == $past(st_r.idx)))
    else $error("colour selector did not step");

  a_addr_load: assert property (@(posedge clk) disable iff (!nrst) // RQ22
    (wr && addr == `LRG_OFF_TBL_ADDR) |=> (st_r.col == lrg_pkg::LRG_RED
    && st_r.idx == $past(wdata)))
    else $error("address write did not load pointer");

  // staging, commit and read data
  a_red_stage: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    (s_data_wr ##0 (st_r.col == lrg_pkg::LRG_RED))
    |=> st_r.stage_r == $past(wdata[`LRG_TBL_DATA_LSB +: TBL_W]))
    else $error("red value not staged");

  a_grn_stage: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    (s_data_wr ##0 (st_r.col == lrg_pkg::LRG_GREEN))
    |=> st_r.stage_g == $past(wdata[`LRG_TBL_DATA_LSB +: TBL_W]))
    else $error("green value not staged");

  a_blue_commit: assert property (@(posedge clk) disable iff (!nrst) // RQ3 RQ21
    s_blue_wr |=> (tbl_blu[$past(st_r.idx)] == $past(wdata[`LRG_TBL_DATA_LSB +: TBL_W])
    && tbl_red[$past(st_r.idx)] == $past(st_r.stage_r)
    && tbl_grn[$past(st_r.idx)] == $past(st_r.stage_g)))
    else $error("entry not committed on blue write");

  a_data_read: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    s_data_rd |=> rdata[3:0] == 4'h0)
    else $error("table read low nibble not zero");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    !rd |=> rdata == 8'h00)
    else $error("read data stands beyond one cycle");

  // general pins
  a_pin_drive: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    (wr && addr == `LRG_OFF_PIN_DIR) ##1 !wr |=>
    (pin_oe == ($past(st_r.dir) & ~$past(pin_dedicated))))
    else $error("pin enable not following direction");

  a_pin_gate: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    (pin_out & ~pin_oe) == '0)
    else $error("pin value driven while not enabled");

  a_pin_dedic: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    $past(pin_dedicated) != '0 |-> (pin_oe & $past(pin_dedicated)) == '0)
    else $error("dedicated pin driven");

  a_in_read: assert property (@(posedge clk) disable iff (!nrst) // RQ4
    (rd && addr == `LRG_OFF_PIN_LVL)
    |=> ((rdata[NPINS-1:0] ^ $past(st_r.pin_sync)) & ~$past(st_r.dir)) == '0)
    else $error("input pin level read wrong");

  a_out_read: assert property (@(posedge clk) disable iff (!nrst) // RQ24
    (rd && addr == `LRG_OFF_PIN_LVL)
    |=> ((rdata[NPINS-1:0] ^ $past(st_r.lvl)) & $past(st_r.dir)) == '0)
    else $error("output pin level read wrong");

  // scratch
  a_scratch_rb: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    (wr && addr == `LRG_OFF_SCRATCH) ##1 (rd && addr == `LRG_OFF_SCRATCH && !wr)
    |=> rdata == $past(wdata, 2))
    else $error("scratch readback wrong");

  a_scratch_hold: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    (nrst && !(wr && addr == `LRG_OFF_SCRATCH)) |=> st_r.scratch == $past(st_r.scratch))
    else $error("scratch changed without a write");

  // rotation mode and clocks
  a_landscape: assert property (@(posedge clk) disable iff (!nrst) // RQ8
    !st_r.rot[`LRG_ROT_EN_BIT] |=> (disp_mode == lrg_pkg::LRG_LANDSCAPE
    || $past(wr && addr == `LRG_OFF_ROT_MODE)))
    else $error("rotation active while disabled");

  a_alt_mode: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    (nrst && st_r.rot[`LRG_ROT_EN_BIT] && st_r.rot[`LRG_ROT_VAR_BIT]
    && !(wr && addr == `LRG_OFF_ROT_MODE)) |=> disp_mode == lrg_pkg::LRG_ROT_ALTERNATE)
    else $error("alternate rotated mode not selected");

  a_def_clk: assert property (@(posedge clk) disable iff (!nrst) // RQ12
    disp_mode == lrg_pkg::LRG_ROT_DEFAULT |-> clk_sel.pix_log2 == clk_sel.mem_log2)
    else $error("default rotated clocks differ");

  a_alt_clk: assert property (@(posedge clk) disable iff (!nrst) // RQ13
    disp_mode == lrg_pkg::LRG_ROT_ALTERNATE
    |-> clk_sel.pix_log2 == clk_sel.mem_log2 + 4'h1)
    else $error("alternate rotated clocks wrong");

  a_land_clk: assert property (@(posedge clk) disable iff (!nrst) // RQ11 RQ14
    (disp_mode == lrg_pkg::LRG_LANDSCAPE && $past(nrst))
    |-> (clk_sel.mem_use_cfg && clk_sel.pix_log2 <= 4'h1))
    else $error("landscape clock selection wrong");

  a_pre_clk: assert property (@(posedge clk) disable iff (!nrst) // RQ14
    (nrst && $past(nrst) && base_prescale) |=> clk_sel.pix_log2 != 4'h0)
    else $error("prescale did not halve pixel clock");

  // stride and frame timing
  a_stride_zero: assert property (@(posedge clk) disable iff (!nrst) // RQ15
    (nrst && st_r.stride == 8'h00 && !(wr && addr == `LRG_OFF_STRIDE))
    |=> line_stride == 9'h100)
    else $error("zero stride not 256");

  a_stride_val: assert property (@(posedge clk) disable iff (!nrst) // RQ15
    (nrst && st_r.stride != 8'h00 && !(wr && addr == `LRG_OFF_STRIDE))
    |=> line_stride == {1'b0, $past(st_r.stride)})
    else $error("nonzero stride wrong");

  a_hdp_calc: assert property (@(posedge clk) disable iff (!nrst) // RQ17
    nrst |=> timing.horizontal_display_period == ({4'h0, $past(hsize_field)} + 11'h001) * 11'h008)
    else $error("horizontal display period wrong");

  a_hbp_calc: assert property (@(posedge clk) disable iff (!nrst) // RQ18
    nrst |=> timing.hbp == ({4'h0, $past(hblank_field)} + 9'h004) * 9'h008)
    else $error("horizontal blank period wrong");

  a_vdp_calc: assert property (@(posedge clk) disable iff (!nrst) // RQ19 RQ20
    nrst |=> (timing.vertical_display_period == {1'b0, $past(vsize_field)} + 11'h001
    && timing.vbp == $past(vblank_field)))
    else $error("vertical periods wrong");

endmodule // lrg_regs

/* File: core/lrg_consts.svh */
// register offsets, field positions and reset values for the table, pin and rotation slice
`ifndef LRG_CONSTS_SVH
`define LRG_CONSTS_SVH
`define LRG_OFF_TBL_ADDR 8'h15
`define LRG_OFF_TBL_DATA 8'h17
`define LRG_OFF_PIN_DIR 8'h18
`define LRG_OFF_PIN_LVL 8'h19
`define LRG_OFF_SCRATCH 8'h1A
`define LRG_OFF_ROT_MODE 8'h1B
`define LRG_OFF_STRIDE 8'h1C
`define LRG_OFF_TEST_LO 8'h1E
`define LRG_OFF_TEST_HI 8'h1F
`define LRG_TBL_DATA_LSB 4
`define LRG_ROT_EN_BIT 7
`define LRG_ROT_VAR_BIT 6
`define LRG_ROT_PRE_BIT 4
`define LRG_ROT_RSVD_BIT 2
`define LRG_ROT_SEL_LSB 0
`define LRG_ROT_WR_MASK 8'hD3
`define LRG_RST_BYTE 8'h00
`define LRG_HDP_MULT 8
`define LRG_HBP_ADD 4
`define LRG_STRIDE_ZERO 9'h100
`endif

/* File: core/lrg_pkg.sv */
// types for the table, pin and rotation register slice
package lrg_pkg;
  typedef enum logic [1:0] {
    LRG_RED = 2'b00,
    LRG_GREEN = 2'b01,
    LRG_BLUE = 2'b10
  } lrg_colour_t;

  typedef enum logic [1:0] {
    LRG_LANDSCAPE = 2'b00,
    LRG_ROT_DEFAULT = 2'b01,
    LRG_ROT_ALTERNATE = 2'b10
  } lrg_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lrg_bus_req_t;

  typedef struct packed {
    logic [3:0] pix_log2;
    logic [3:0] mem_log2;
    logic mem_use_cfg;
  } lrg_clk_sel_t;

  typedef struct packed {
    logic [10:0] horizontal_display_period;
    logic [8:0] hbp;
    logic [10:0] vertical_display_period;
    logic [5:0] vbp;
  } lrg_timing_t;
endpackage

/* File: test/test_lrg_regs.sv */
// self-checking bench for the table, pin, rotation and timing register slice
`timescale 1ns/1ns
`include "lrg_consts.svh"
module test_lrg_regs;
  logic clk;
  logic nrst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic rd_q;
  logic [7:0] rdata;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] pin_ded;
  logic base_prescale;
  logic mem_clk_cfg;
  logic [6:0] hs;
  logic [4:0] hb;
  logic [9:0] vs;
  logic [5:0] vb;
  lrg_pkg::lrg_mode_t disp_mode;
  lrg_pkg::lrg_clk_sel_t clk_sel;
  logic [8:0] line_stride;
  lrg_pkg::lrg_timing_t timing;
  int err_count;
  int comparisons;
  logic [15:0] rq[$];
  logic [15:0] e;
  logic [7:0] w;
  logic [4:0] dir;
  logic [4:0] lvl;
  logic [3:0] tv[6];

  lrg_regs dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_dedicated(pin_ded), .base_prescale(base_prescale), .mem_clk_cfg(mem_clk_cfg),
    .hsize_field(hs), .hblank_field(hb), .vsize_field(vs), .vblank_field(vb),
    .disp_mode(disp_mode), .clk_sel(clk_sel), .line_stride(line_stride), .timing(timing));

  always #10 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // the note carries mask and expected data; the monitor compares masked read data
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back({m, x & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  always @(posedge clk) rd_q <= rd;

  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      e = rq.pop_front();
      check({8'h00, rdata & e[15:8]}, {8'h00, e[7:0]});
    end
  end

  function automatic logic [8:0] exp_clk(input logic [5:0] k);
    logic [3:0] pix;
    logic [3:0] mem;
    logic [1:0] s;
    s = k[3:2];
    if (!k[5]) begin
      pix = 4'h0;
      mem = {3'h0, k[0]};
    end else if (!k[4]) begin
      pix = {2'h0, s};
      mem = {2'h0, s};
    end else begin
      pix = (s == 2'h0) ? 4'h1 : {2'h0, s};
      mem = (s < 2'h2) ? 4'h0 : {2'h0, s} - 4'h1;
    end
    return {pix + {3'h0, k[1]}, mem + {3'h0, k[1]}, ~k[5]};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // whole run is well under 3000 cycles
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h4396e309));
    {clk, nrst, addr, wdata, wr, rd, rd_q, pin_in, pin_ded} = '0;
    {base_prescale, mem_clk_cfg, hs, hb, vs, vb} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({14'h0, disp_mode}, {14'h0, lrg_pkg::LRG_LANDSCAPE});
    check({11'h0, pin_oe}, 16'h0000);
    check({7'h0, line_stride}, 16'h0100);
    foreach (tv[i]) rd_reg(8'h18 + 8'(i), 8'hFF, 8'h00);
    w = 8'($urandom);
    wr_reg(`LRG_OFF_SCRATCH, w);
    wr_reg(8'h30, ~w);
    rd_reg(`LRG_OFF_SCRATCH, 8'hFF, w);
    // write then read with no gap between strobes
    @(posedge clk);
    addr <= `LRG_OFF_SCRATCH;
    wdata <= ~w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    rq.push_back({8'hFF, ~w});
    @(posedge clk);
    rd <= 1'b0;
    // factory test places are read only, never written
    rd_reg(`LRG_OFF_TEST_LO, 8'hFF, 8'h00);
    rd_reg(`LRG_OFF_TEST_HI, 8'hFF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {dir, lvl} = 10'($urandom);
      @(posedge clk);
      pin_in <= 5'($urandom);
      pin_ded <= 5'($urandom);
      wr_reg(`LRG_OFF_PIN_DIR, {3'h0, dir});
      wr_reg(`LRG_OFF_PIN_LVL, {3'h0, lvl});
      @(negedge clk);
      check({11'h0, pin_oe}, {11'h0, dir & ~pin_ded});
      check({11'h0, pin_out}, {11'h0, lvl & dir & ~pin_ded});
      @(posedge clk);
      pin_ded <= 5'h00;
      rd_reg(`LRG_OFF_PIN_LVL, 8'h1F, {3'h0, (dir & lvl) | (~dir & pin_in)});
      rd_reg(`LRG_OFF_PIN_DIR, 8'h1F, {3'h0, dir});
      @(negedge clk);
      check({11'h0, pin_oe}, {11'h0, dir});
    end
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      base_prescale <= i[1];
      mem_clk_cfg <= i[0];
      w = {i[5], i[4], 3'($urandom), 1'b0, i[3:2]} & 8'hFB;
      wr_reg(`LRG_OFF_ROT_MODE, w);
      @(negedge clk);
      check({14'h0, disp_mode}, {14'h0, !i[5] ? 2'h0 : (i[4] ? 2'h2 : 2'h1)});
      check({7'h0, clk_sel}, {7'h0, exp_clk(6'(i))});
      rd_reg(`LRG_OFF_ROT_MODE, 8'hFF, w & 8'hD3);
    end
    @(posedge clk);
    nrst <= 1'b0;
    @(negedge clk);
    check({14'h0, disp_mode}, {14'h0, lrg_pkg::LRG_LANDSCAPE});
    @(posedge clk);
    nrst <= 1'b1;
    foreach (tv[i]) begin
      w = (i < 2) ? 8'(i * 255) : 8'($urandom);
      wr_reg(`LRG_OFF_STRIDE, w);
      @(negedge clk);
      check({7'h0, line_stride}, (w == 8'h00) ? 16'h0100 : {8'h00, w});
      rd_reg(`LRG_OFF_STRIDE, 8'hFF, w);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {hs, hb, vs, vb} <= 28'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({5'h0, timing.horizontal_display_period}, 16'(({4'h0, hs} + 11'h001) << 3));
      check({7'h0, timing.hbp}, 16'(({4'h0, hb} + 9'h004) << 3));
      check({5'h0, timing.vertical_display_period}, 16'({1'b0, vs} + 11'h001));
      check({10'h0, timing.vbp}, {10'h0, vb});
    end
    // index 255 then wraps to index 0 without a new address write
    foreach (tv[i]) tv[i] = 4'($urandom);
    wr_reg(`LRG_OFF_TBL_ADDR, 8'hFF);
    foreach (tv[i]) wr_reg(`LRG_OFF_TBL_DATA, {tv[i], 4'h0});
    wr_reg(`LRG_OFF_TBL_ADDR, 8'hFF);
    foreach (tv[i]) rd_reg(`LRG_OFF_TBL_DATA, 8'hF0, {tv[i], 4'h0});
    wr_reg(`LRG_OFF_TBL_ADDR, 8'h00);
    wr_reg(`LRG_OFF_TBL_DATA, {~tv[3], 4'h0});
    wr_reg(`LRG_OFF_TBL_DATA, {~tv[4], 4'h0});
    wr_reg(`LRG_OFF_TBL_ADDR, 8'h00);
    for (int i = 3; i < 6; i++) rd_reg(`LRG_OFF_TBL_DATA, 8'hF0, {tv[i], 4'h0});
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // test_lrg_regs
